// ==== rtl/power_mode_controller.sv ====
`timescale 1ns/1ps
module power_mode_controller #(
  parameter int SETTLE_SHORT_CYC = pwr_mode_pkg::SETTLE_SHORT,
  parameter int SETTLE_LONG_CYC = pwr_mode_pkg::SETTLE_LONG
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // classic wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // cpu side
  input wire pwr_mode_pkg::cpu_req_t i_cpu_req,
  input wire logic i_watchdog_active,
  input wire logic [pwr_mode_pkg::WK_N-1:0] i_wake_irq,
  output pwr_mode_pkg::cpu_wake_t o_cpu_wake,
  output logic o_watchdog_reset,
  // clock tree
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_en,
  output logic o_time_base_en,
  output logic [2:0] o_mode
);
  localparam int CNT_W = $clog2(SETTLE_LONG_CYC + 1);

  pwr_mode_pkg::pmode_t state_reg, state_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [1:0] opt_reg, opt_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  pwr_mode_pkg::cpu_wake_t wake_reg, wake_next;
  logic wdg_rst_reg, wdg_rst_next;
  logic [pwr_mode_pkg::WK_N-1:0] irq_s1_reg, irq_s2_reg;
  logic tick;
  logic wb_req;
  logic halt_cmd;
  logic wake_full, wake_active, wake_run;
  logic oscillator_interrupt_enable, slow_en;
  logic [1:0] prescale;

  assign oscillator_interrupt_enable = ctrl_reg[pwr_mode_pkg::OIE_BIT];
  assign slow_en = ctrl_reg[pwr_mode_pkg::SMS_BIT];
  assign prescale = ctrl_reg[pwr_mode_pkg::CP_LSB +: 2];

  // settle length from option bit, in master clock cycles
  function automatic logic [CNT_W-1:0] settle_len(input logic long_sel);
    settle_len = long_sel ? CNT_W'(SETTLE_LONG_CYC - 1) : CNT_W'(SETTLE_SHORT_CYC - 1);
  endfunction

  // slow clock enable divider
  clk_prescaler #(
    .CNT_W(4)
  ) u_prescaler (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_slow_en(slow_en),
    .i_prescale(prescale),
    .o_tick(tick)
  );

  // wake lines come from other logic and pins: two-stage synchroniser
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
    end else begin
      irq_s1_reg <= i_wake_irq;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // wake qualification per mode
  always_comb begin
    wake_run = |irq_s2_reg;
    wake_active = irq_s2_reg[pwr_mode_pkg::WK_TIMEBASE];
    wake_full = irq_s2_reg[pwr_mode_pkg::WK_TIMEBASE] |
                (|irq_s2_reg[pwr_mode_pkg::WK_EXT_LSB +: 4]) |
                irq_s2_reg[pwr_mode_pkg::WK_SPI];
  end

  assign halt_cmd = i_cpu_req.halt && (i_cpu_req.opcode == pwr_mode_pkg::OPC_HALT);

  // mode sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wake_next = '0;
    wdg_rst_next = 1'b0;
    case (state_reg)
      pwr_mode_pkg::ST_RUN: begin
        if (i_cpu_req.wait_for_interrupt_instr) begin
          state_next = pwr_mode_pkg::ST_WAIT;
          wake_next.force_mask = 1'b1;
          wake_next.mask_val = pwr_mode_pkg::MASK_ALL_EN;
        end else if (halt_cmd) begin
          if (i_watchdog_active && opt_reg[pwr_mode_pkg::OPT_WATCHDOG_HALT_OPTION_BIT] && !oscillator_interrupt_enable) begin
            wdg_rst_next = 1'b1;
          end else begin
            state_next = oscillator_interrupt_enable ? pwr_mode_pkg::ST_ACT_HALT : pwr_mode_pkg::ST_HALT;
            wake_next.force_mask = 1'b1;
            wake_next.mask_val = pwr_mode_pkg::MASK_ALL_EN;
          end
        end
      end
      pwr_mode_pkg::ST_WAIT: begin
        if (wake_run) begin
          state_next = pwr_mode_pkg::ST_RUN;
          wake_next.wake = 1'b1;
        end
      end
      pwr_mode_pkg::ST_ACT_HALT: begin
        if (wake_active) begin
          state_next = pwr_mode_pkg::ST_RUN;
          wake_next.wake = 1'b1;
        end
      end
      pwr_mode_pkg::ST_HALT: begin
        if (wake_full) begin
          state_next = pwr_mode_pkg::ST_SETTLE;
          cnt_next = settle_len(opt_reg[pwr_mode_pkg::OPT_LONG_BIT]);
        end
      end
      pwr_mode_pkg::ST_SETTLE: begin
        if (cnt_reg == '0) begin
          state_next = pwr_mode_pkg::ST_RUN;
          wake_next.wake = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = pwr_mode_pkg::ST_RUN;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= pwr_mode_pkg::ST_RUN;
      cnt_reg <= '0;
      wake_reg <= '0;
      wdg_rst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wake_reg <= wake_next;
      wdg_rst_reg <= wdg_rst_next;
    end
  end

  // clock gating per mode
  always_comb begin
    o_cpu_clk_en = 1'b0;
    o_periph_clk_en = 1'b0;
    o_osc_en = 1'b1;
    o_time_base_en = 1'b1;
    case (state_reg)
      pwr_mode_pkg::ST_RUN: begin
        o_cpu_clk_en = tick;
        o_periph_clk_en = tick;
      end
      pwr_mode_pkg::ST_WAIT: begin
        o_periph_clk_en = tick;
      end
      pwr_mode_pkg::ST_ACT_HALT: begin
        o_time_base_en = 1'b1;
      end
      pwr_mode_pkg::ST_HALT: begin
        o_osc_en = 1'b0;
        o_time_base_en = 1'b0;
      end
      pwr_mode_pkg::ST_SETTLE: begin
        o_time_base_en = 1'b0;
      end
      default: begin
        o_osc_en = 1'b1;
      end
    endcase
  end

  assign o_mode = state_reg;
  assign o_cpu_wake = wake_reg;
  assign o_watchdog_reset = wdg_rst_reg;

  // wishbone register access, one wait state
  assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
  always_comb begin
    ctrl_next = ctrl_reg;
    opt_next = opt_reg;
    ack_next = wb_req;
    rdat_next = rdat_reg;
    if (wb_req) begin
      rdat_next = '0;
      case (i_wb_adr)
        pwr_mode_pkg::ADDR_CLK_CTRL: begin
          rdat_next = {28'h0, ctrl_reg};
          if (i_wb_we && i_wb_sel[0]) begin
            ctrl_next = i_wb_dat[3:0];
          end
        end
        pwr_mode_pkg::ADDR_STATUS: begin
          rdat_next = {28'h0, o_cpu_clk_en, state_reg};
        end
        pwr_mode_pkg::ADDR_OPTION: begin
          rdat_next = {30'h0, opt_reg};
          if (i_wb_we && i_wb_sel[0]) begin
            opt_next = i_wb_dat[1:0];
          end
        end
        default: begin
          rdat_next = '0;
        end
      endcase
    end
  end

  // register file
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= pwr_mode_pkg::CLK_CTRL_RST;
      opt_reg <= pwr_mode_pkg::OPT_RST;
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      opt_reg <= opt_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
endmodule

// ==== rtl/pwr_mode_pkg.sv ====
package pwr_mode_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OPTION = 8'h08;
  // clock control register fields
  localparam int SMS_BIT = 0;
  localparam int CP_LSB = 1;
  localparam int OIE_BIT = 3;
  // option register fields
  localparam int OPT_LONG_BIT = 0;
  localparam int OPT_WATCHDOG_HALT_OPTION_BIT = 1;
  localparam logic [3:0] CLK_CTRL_RST = 4'h0;
  localparam logic [1:0] OPT_RST = 2'h0;
  // cpu opcodes that request low power
  localparam logic [7:0] OPC_HALT = 8'h8e;
  // interrupt mask forced on wait / halt entry
  localparam logic [1:0] MASK_ALL_EN = 2'h2;
  // settle delay in master clock cycles
  localparam int SETTLE_SHORT = 256;
  localparam int SETTLE_LONG = 4096;
  // wake source bit positions
  localparam int WK_TIMEBASE = 0;
  localparam int WK_EXT_LSB = 1;
  localparam int WK_SPI = 5;
  localparam int WK_TIMER_A = 6;
  localparam int WK_TIMER_B = 7;
  localparam int WK_SCI = 8;
  localparam int WK_N = 9;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_WAIT = 3'h1,
    ST_ACT_HALT = 3'h2,
    ST_HALT = 3'h3,
    ST_SETTLE = 3'h4
  } pmode_t;

  // cpu request bundle
  typedef struct packed {
    logic wait_for_interrupt_instr;
    logic halt;
    logic [7:0] opcode;
  } cpu_req_t;

  // wake-up bundle to cpu
  typedef struct packed {
    logic wake;
    logic force_mask;
    logic [1:0] mask_val;
  } cpu_wake_t;
endpackage

// ==== rtl/clk_prescaler.sv ====
`timescale 1ns/1ps
// one-cycle enable pulse at master rate divided by 2,4,8 or 16
module clk_prescaler #(
  parameter int CNT_W = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_slow_en,
  input wire logic [1:0] i_prescale,
  output logic o_tick
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] limit;

  // divide ratio 2^(prescale+1) minus one
  always_comb begin
    limit = CNT_W'((5'h2 << i_prescale) - 5'h1);
    cnt_next = cnt_reg;
    o_tick = 1'b1;
    if (i_slow_en) begin
      o_tick = (cnt_reg == limit);
      cnt_next = o_tick ? '0 : cnt_reg + 1'b1;
    end else begin
      cnt_next = '0;
    end
  end

  // counter register
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ==== bench/power_mode_controller_assertions.sv ====
`timescale 1ns/1ps
// port checks for the power mode controller
module pmc_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire pwr_mode_pkg::cpu_req_t i_cpu_req,
  input wire logic i_watchdog_active,
  input wire logic [8:0] i_wake_irq,
  input wire pwr_mode_pkg::cpu_wake_t o_cpu_wake,
  input wire logic o_watchdog_reset,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_en,
  input wire logic o_time_base_en,
  input wire logic [2:0] o_mode
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  wire logic run_w = o_mode == 3'h0;
  ack_latency_a:
    assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  wait_entry_a:
    assert property (run_w && i_cpu_req.wait_for_interrupt_instr |=> o_mode == 3'h1 && o_cpu_wake == 4'h6) else $error("wait entry");
  halt_entry_a:
    assert property (run_w && i_cpu_req.halt && i_cpu_req.opcode == 8'h8e |=> o_watchdog_reset
      || (o_mode inside {3'h2, 3'h3} && o_cpu_wake == 4'h6)) else $error("halt entry");
  stray_opcode_a:
    assert property (run_w && !i_cpu_req.wait_for_interrupt_instr && i_cpu_req.opcode != 8'h8e |=> run_w) else $error("stray halt");
  active_clk_a:
    assert property (o_mode == 3'h2 |-> o_osc_en && o_time_base_en && !o_periph_clk_en) else $error("active clocks");
  cpu_gate_a:
    assert property (!run_w |-> !o_cpu_clk_en) else $error("cpu clock on");
  active_exit_a:
    assert property (o_mode == 3'h2 ##1 o_mode != 3'h2 |-> run_w) else $error("active exit");
  full_exit_a:
    assert property (o_mode == 3'h3 ##1 o_mode != 3'h3 |-> o_mode == 3'h4) else $error("full exit");
endmodule
bind power_mode_controller pmc_checker chk (.*);

// ==== bench/cpu_irq_model.sv ====
`timescale 1ns/1ps
// cpu core and interrupt sources facing the controller
module cpu_irq_model (
  input wire logic i_ref_clk,
  input wire pwr_mode_pkg::cpu_wake_t i_wake,
  output pwr_mode_pkg::cpu_req_t o_req,
  output logic [8:0] o_irq
);
  logic [1:0] mask_reg = 2'h3;
  initial o_req = '0;
  initial o_irq = '0;
  // forced mask taken; pending flags cleared once serviced
  always @(posedge i_ref_clk) begin
    if (i_wake.force_mask) mask_reg <= i_wake.mask_val;
    if (i_wake.wake) o_irq <= '0;
  end
  // one-cycle instruction pulse
  task exec(input logic w, input logic h, input logic [7:0] op);
    @(posedge i_ref_clk);
    o_req <= {w, h, op};
    @(posedge i_ref_clk);
    o_req <= '0;
  endtask
  task raise(input logic [8:0] b);
    @(posedge i_ref_clk);
    o_irq <= o_irq | b;
  endtask
endmodule

// ==== bench/power_mode_controller_tb.sv ====
`timescale 1ns/1ps
// bench for register access, slow, wait and halt modes
module power_mode_controller_tb;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wb_cyc;
  logic i_wb_stb;
  logic i_wb_we;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat;
  logic i_watchdog_active;
  pwr_mode_pkg::cpu_req_t i_cpu_req;
  pwr_mode_pkg::cpu_wake_t o_cpu_wake;
  logic [8:0] i_wake_irq;
  logic [31:0] o_wb_dat, q;
  logic o_wb_ack, o_watchdog_reset, o_cpu_clk_en, o_periph_clk_en, o_osc_en, o_time_base_en, woke, wdg_seen;
  logic [2:0] o_mode;
  int failures = 0, total_checks = 0, cycles = 0, settle_n, n;
  always #2.5 i_ref_clk = ~i_ref_clk;
  power_mode_controller #(.SETTLE_SHORT_CYC(8), .SETTLE_LONG_CYC(16)) dut (.*);
  cpu_irq_model cpu (.i_ref_clk(i_ref_clk), .i_wake(o_cpu_wake), .o_req(i_cpu_req), .o_irq(i_wake_irq));
  // timeout and sticky pulse observers
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (o_cpu_wake.wake) woke <= 1'b1;
    if (o_watchdog_reset) wdg_seen <= 1'b1;
    if (o_mode === 3'h4) settle_n <= settle_n + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task finish_test;
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single access held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task wait_mode(input logic [2:0] m);
    n = 0;
    while (o_mode !== m && n < 200) begin
      @(posedge i_ref_clk);
      n++;
    end
    chk("mode", m, o_mode);
  endtask
  task t_slow;
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 8'h00, p * 2 + 1);
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", p * 2 + 1, q);
      repeat (4) @(posedge i_ref_clk);
      n = 0;
      repeat (64) @(posedge i_ref_clk) n += o_cpu_clk_en;
      chk("cpu ticks", 64 >> (p + 1), n);
    end
  endtask
  task t_wait;
    cpu.exec(1'b1, 1'b0, 8'h00);
    wait_mode(3'h1);
    n = 0;
    repeat (64) @(posedge i_ref_clk) n += o_periph_clk_en;
    chk("slow wait ticks", 32'h4, n);
    chk("mask", 32'h2, cpu.mask_reg);
    woke = 1'b0;
    cpu.raise(9'h040);
    wait_mode(3'h0);
    @(posedge i_ref_clk);
    chk("wake", 32'h1, woke);
  endtask
  task t_active;
    i_watchdog_active <= 1'b1;
    wb(1'b1, 8'h00, 32'h8);
    wb(1'b1, 8'h08, 32'h2);
    wdg_seen = 1'b0;
    cpu.exec(1'b0, 1'b1, 8'h8e);
    wait_mode(3'h2);
    cpu.raise(9'h0e0);
    repeat (10) @(posedge i_ref_clk);
    chk("spi wake", 32'h2, o_mode);
    chk("wdg reset", 32'h0, wdg_seen);
    settle_n = 0;
    cpu.raise(9'h001);
    wait_mode(3'h0);
    chk("settle", 32'h0, settle_n);
  endtask
  task t_full;
    i_watchdog_active <= 1'b0;
    wb(1'b1, 8'h00, 32'h0);
    for (int l = 0; l < 2; l++) begin
      wb(1'b1, 8'h08, l);
      cpu.exec(1'b0, 1'b1, 8'h8e);
      wait_mode(3'h3);
      chk("osc", 32'h0, o_osc_en);
      cpu.raise(9'h1c0);
      repeat (10) @(posedge i_ref_clk);
      chk("timer wake", 32'h3, o_mode);
      settle_n = 0;
      cpu.raise(9'h004);
      wait_mode(3'h0);
      chk("settle", 8 << l, settle_n);
    end
  endtask
  task t_wdg;
    i_watchdog_active <= 1'b1;
    wb(1'b1, 8'h08, 32'h2);
    wdg_seen = 1'b0;
    cpu.exec(1'b0, 1'b1, 8'h8e);
    repeat (4) @(posedge i_ref_clk);
    chk("wdg reset", 32'h1, wdg_seen);
    chk("no halt", 32'h0, o_mode);
    cpu.exec(1'b0, 1'b1, 8'h9e);
    repeat (4) @(posedge i_ref_clk);
    chk("stray opcode", 32'h0, o_mode);
  endtask
  // lane 0 off drops the write; status shows run with cpu clock on
  task t_sel;
    i_wb_sel <= 4'he;
    wb(1'b1, 8'h00, 32'h1);
    i_wb_sel <= 4'hf;
    wb(1'b0, 8'h00, 32'h0);
    chk("sel write", 32'h0, q);
    wb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h8, q);
  endtask
  initial begin
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    i_wb_adr <= 8'h00;
    i_wb_sel <= 4'hf;
    i_wb_dat <= 32'h0;
    i_watchdog_active <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    chk("reset mode", 32'h0, o_mode);
    chk("reset cpu clk", 32'h1, o_cpu_clk_en);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, q);
    t_slow();
    t_wait();
    t_active();
    t_full();
    t_wdg();
    t_sel();
    finish_test();
  end
endmodule
